/* File: ramp_jerk_target_param_regs.sv */
// Jerk, clock frequency and position parameter registers behind an APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/100ps

// Functional notes
// - Hold 24-bit unsigned jerk for first bow of acceleration.
// - Hold 24-bit unsigned jerk for second bow of acceleration.
// - Hold 24-bit unsigned jerk for first bow of deceleration.
// - Hold 24-bit unsigned jerk for second bow of deceleration.
// - Frequency mode: jerk is an integer pulses per second cubed, 1 to 16M.
// - Direct mode: acceleration change per clock is jerk over two to the 53.
// - Hold 25-bit clock frequency in hertz, printed reset, valid 4.2 to 30 MHz.
// - Hold signed 32-bit lower soft stop position.
// - Hold signed 32-bit upper soft stop position.
// - Latch select 0: shared address reads the captured position.
// - Latch select 1: shared address reads the signed turn count.
// - Write to shared address loads 31-bit span; position stays in minus span to span-1.
// - Hold 32-bit goal position for positioning mode.
module ramp_jerk_target_param_regs
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire ramp_param_pkg::apb_req_type apb_i,
	output ramp_param_pkg::apb_rsp_type apb_o,
	// Motion core state
	input wire ramp_param_pkg::bow_phase_type bow_phase_i,
	input wire logic [ramp_param_pkg::POS_W-1:0] actual_position_i,
	input wire logic capture_strobe_i,
	input wire logic [ramp_param_pkg::POS_W-1:0] turn_count_i,
	// Ramp parameters
	output ramp_param_pkg::jerk_set_type jerk_set_o,
	output logic [ramp_param_pkg::JERK_W-1:0] active_jerk_o,
	output logic direct_mode_o,
	output logic [ramp_param_pkg::FREQ_W-1:0] clock_frequency_hz_o,
	// Positions
	output logic [ramp_param_pkg::POS_W-1:0] compare_position_o,
	output logic [ramp_param_pkg::POS_W-1:0] soft_limit_low_o,
	output logic [ramp_param_pkg::POS_W-1:0] soft_limit_high_o,
	output logic [ramp_param_pkg::POS_W-1:0] home_position_o,
	output logic [ramp_param_pkg::SPAN_W-1:0] circular_span_o,
	output logic [ramp_param_pkg::POS_W-1:0] goal_position_o,
	output logic goal_update_o,
	// Status
	output logic compare_match_o,
	output logic below_low_limit_o,
	output logic above_high_limit_o,
	output logic outside_span_o,
	output logic clock_freq_ok_o,
	output logic jerk_ok_o
);
	import ramp_param_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	jerk_set_type jerk_r;
	logic [FREQ_W-1:0] freq_r;
	logic [POS_W-1:0] compare_r;
	logic [POS_W-1:0] low_limit_r;
	logic [POS_W-1:0] high_limit_r;
	logic [POS_W-1:0] home_r;
	logic [POS_W-1:0] capture_r;
	logic [SPAN_W-1:0] span_r;
	logic [POS_W-1:0] goal_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic goal_update_r;
	logic [STAT_W-1:0] stat_r;
	logic [STAT_W-1:0] stat_nxt;
	logic [JERK_W-1:0] active_jerk_r;
	logic [DATA_W-1:0] prdata_r;
	logic pslverr_r;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire logic [IDX_W-1:0] idx = apb_i.paddr[IDX_W+1:2];
	wire logic aligned = (apb_i.paddr[1:0] == 2'h0)
		&& (apb_i.paddr[ADDR_W-1:IDX_W+2] == '0);
	wire logic setup = apb_i.psel && !apb_i.penable;
	wire logic access = apb_i.psel && apb_i.penable;
	wire logic wr = access && apb_i.pwrite && !pslverr_r;

	wire logic sel_aj1 = aligned && (idx == IDX_ACCEL_JERK_FIRST);
	wire logic sel_aj2 = aligned && (idx == IDX_ACCEL_JERK_SECOND);
	wire logic sel_dj1 = aligned && (idx == IDX_DECEL_JERK_FIRST);
	wire logic sel_dj2 = aligned && (idx == IDX_DECEL_JERK_SECOND);
	wire logic sel_freq = aligned && (idx == IDX_CLOCK_FREQUENCY_HZ);
	wire logic sel_cmp = aligned && (idx == IDX_COMPARE_POSITION);
	wire logic sel_low = aligned && (idx == IDX_SOFT_LIMIT_LOW);
	wire logic sel_high = aligned && (idx == IDX_SOFT_LIMIT_HIGH);
	wire logic sel_home = aligned && (idx == IDX_HOME_POSITION);
	wire logic sel_shared = aligned && (idx == IDX_CAPTURE_OR_SPAN);
	wire logic sel_goal = aligned && (idx == IDX_GOAL_POSITION);
	wire logic sel_ctrl = aligned && (idx == IDX_PARAM_CONTROL);
	wire logic sel_stat = aligned && (idx == IDX_PARAM_STATUS);
	wire logic mapped = sel_aj1 || sel_aj2 || sel_dj1 || sel_dj2 || sel_freq || sel_cmp
		|| sel_low || sel_high || sel_home || sel_shared || sel_goal || sel_ctrl
		|| sel_stat;

	// Bus data as plain nets, so that every caller of merge sees them as operands
	wire logic [DATA_W-1:0] wdata = apb_i.pwdata;
	wire logic [STRB_W-1:0] wstrb = apb_i.pstrb;

	// Byte-lane merge of write data into the current word
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < STRB_W; b++)
		begin
			if (strb[b])
			begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// Next values on write
	// ----------------------------------------
	// Narrow registers keep only the low bits of their merged word
	wire logic [DATA_W-1:0] aj1_word = merge({8'h00, jerk_r.accel_first}, wdata, wstrb);
	wire logic [DATA_W-1:0] aj2_word = merge({8'h00, jerk_r.accel_second}, wdata, wstrb);
	wire logic [DATA_W-1:0] dj1_word = merge({8'h00, jerk_r.decel_first}, wdata, wstrb);
	wire logic [DATA_W-1:0] dj2_word = merge({8'h00, jerk_r.decel_second}, wdata, wstrb);
	wire logic [DATA_W-1:0] freq_word = merge({7'h00, freq_r}, wdata, wstrb);
	wire logic [DATA_W-1:0] span_word = merge({1'b0, span_r}, wdata, wstrb);
	wire logic [DATA_W-1:0] ctrl_word = merge({30'h00000000, ctrl_r}, wdata, wstrb);
	wire logic [JERK_W-1:0] aj1_nxt = aj1_word[JERK_W-1:0];
	wire logic [JERK_W-1:0] aj2_nxt = aj2_word[JERK_W-1:0];
	wire logic [JERK_W-1:0] dj1_nxt = dj1_word[JERK_W-1:0];
	wire logic [JERK_W-1:0] dj2_nxt = dj2_word[JERK_W-1:0];
	wire logic [FREQ_W-1:0] freq_nxt = freq_word[FREQ_W-1:0];
	wire logic [POS_W-1:0] cmp_nxt = merge(compare_r, wdata, wstrb);
	wire logic [POS_W-1:0] low_nxt = merge(low_limit_r, wdata, wstrb);
	wire logic [POS_W-1:0] high_nxt = merge(high_limit_r, wdata, wstrb);
	wire logic [POS_W-1:0] home_nxt = merge(home_r, wdata, wstrb);
	wire logic [SPAN_W-1:0] span_nxt = span_word[SPAN_W-1:0];
	wire logic [POS_W-1:0] goal_nxt = merge(goal_r, wdata, wstrb);
	wire logic [CTRL_W-1:0] ctrl_nxt = ctrl_word[CTRL_W-1:0];

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire logic latch_sel = ctrl_r[CTRL_LATCH_SEL_BIT];
	wire logic [POS_W-1:0] shared_rd = latch_sel ? turn_count_i : capture_r;
	wire logic [DATA_W-1:0] rd_val =
		sel_aj1 ? {8'h00, jerk_r.accel_first} :
		sel_aj2 ? {8'h00, jerk_r.accel_second} :
		sel_dj1 ? {8'h00, jerk_r.decel_first} :
		sel_dj2 ? {8'h00, jerk_r.decel_second} :
		sel_freq ? {7'h00, freq_r} :
		sel_cmp ? compare_r :
		sel_low ? low_limit_r :
		sel_high ? high_limit_r :
		sel_home ? home_r :
		sel_shared ? shared_rd :
		sel_goal ? goal_r :
		sel_ctrl ? {30'h00000000, ctrl_r} :
		sel_stat ? {25'h0000000, stat_r} :
		32'h00000000;

	// ----------------------------------------
	// Status evaluation
	// ----------------------------------------
	wire logic signed [POS_W-1:0] pos_s = $signed(actual_position_i);
	wire logic signed [POS_W:0] span_hi = $signed({2'b00, span_r}) - 33'sd1;
	wire logic signed [POS_W:0] span_lo = -$signed({2'b00, span_r});
	wire logic signed [POS_W:0] pos_w = {pos_s[POS_W-1], pos_s};
	wire logic jerk_all_ok = (jerk_r.accel_first >= JERK_MIN)
		&& (jerk_r.accel_second >= JERK_MIN) && (jerk_r.decel_first >= JERK_MIN)
		&& (jerk_r.decel_second >= JERK_MIN);

	always_comb
	begin
		stat_nxt = '0;
		stat_nxt[STAT_COMPARE_MATCH_BIT] = (actual_position_i == compare_r);
		stat_nxt[STAT_BELOW_LOW_BIT] = pos_s < $signed(low_limit_r);
		stat_nxt[STAT_ABOVE_HIGH_BIT] = pos_s > $signed(high_limit_r);
		stat_nxt[STAT_OUTSIDE_SPAN_BIT] = (pos_w < span_lo) || (pos_w > span_hi);
		stat_nxt[STAT_CLOCK_OK_BIT] = (freq_r >= FREQ_MIN_HZ) && (freq_r <= FREQ_MAX_HZ);
		// Zero is only legal as a direct-mode step; frequency mode needs 1..16M
		stat_nxt[STAT_JERK_OK_BIT] = ctrl_r[CTRL_DIRECT_MODE_BIT] || jerk_all_ok;
		// Sticky capture flag; a fresh capture wins over the read that clears it
		stat_nxt[STAT_CAPTURED_BIT] = capture_strobe_i
			|| (stat_r[STAT_CAPTURED_BIT] && !(access && !apb_i.pwrite && sel_shared));
	end

	// ----------------------------------------
	// Bow phase selection
	// ----------------------------------------
	// Jerk for the bow now running; its unit follows the mode bit
	wire logic [JERK_W-1:0] phase_jerk =
		(bow_phase_i == BOW_ACCEL_FIRST) ? jerk_r.accel_first :
		(bow_phase_i == BOW_ACCEL_SECOND) ? jerk_r.accel_second :
		(bow_phase_i == BOW_DECEL_FIRST) ? jerk_r.decel_first :
		jerk_r.decel_second;

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end
		else if (setup)
		begin
			prdata_r <= (apb_i.pwrite || !mapped) ? 32'h00000000 : rd_val;
			pslverr_r <= !mapped;
		end
	end

	// ----------------------------------------
	// Jerk, frequency and control registers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			jerk_r <= {JERK_RESET, JERK_RESET, JERK_RESET, JERK_RESET};
			freq_r <= FREQ_RESET;
			ctrl_r <= CTRL_RESET;
		end
		else if (wr)
		begin
			if (sel_aj1)
			begin
				jerk_r.accel_first <= aj1_nxt;
			end
			if (sel_aj2)
			begin
				jerk_r.accel_second <= aj2_nxt;
			end
			if (sel_dj1)
			begin
				jerk_r.decel_first <= dj1_nxt;
			end
			if (sel_dj2)
			begin
				jerk_r.decel_second <= dj2_nxt;
			end
			if (sel_freq)
			begin
				freq_r <= freq_nxt;
			end
			if (sel_ctrl)
			begin
				ctrl_r <= ctrl_nxt;
			end
		end
	end

	// ----------------------------------------
	// Position registers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			compare_r <= POS_RESET;
			low_limit_r <= POS_RESET;
			high_limit_r <= POS_RESET;
			home_r <= POS_RESET;
			span_r <= SPAN_RESET;
			goal_r <= POS_RESET;
		end
		else if (wr)
		begin
			if (sel_cmp)
			begin
				compare_r <= cmp_nxt;
			end
			if (sel_low)
			begin
				low_limit_r <= low_nxt;
			end
			if (sel_high)
			begin
				high_limit_r <= high_nxt;
			end
			if (sel_home)
			begin
				home_r <= home_nxt;
			end
			if (sel_shared)
			begin
				span_r <= span_nxt;
			end
			if (sel_goal)
			begin
				goal_r <= goal_nxt;
			end
		end
	end

	// Captured position follows the trigger, never the bus
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			capture_r <= POS_RESET;
		end
		else if (capture_strobe_i)
		begin
			capture_r <= actual_position_i;
		end
	end

	// ----------------------------------------
	// Derived outputs
	// ----------------------------------------
	// Goal write marks the moment the new profile may start
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			goal_update_r <= 1'b0;
		end
		else
		begin
			goal_update_r <= wr && sel_goal;
		end
	end

	// Status flags lag their inputs by one clock
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stat_r <= '0;
		end
		else
		begin
			stat_r <= stat_nxt;
		end
	end

	// Jerk of the running bow, one clock after a phase change
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			active_jerk_r <= JERK_RESET;
		end
		else
		begin
			active_jerk_r <= phase_jerk;
		end
	end

	// ----------------------------------------
	// Output wiring
	// ----------------------------------------
	assign apb_o.prdata = prdata_r;
	assign apb_o.pready = access;
	assign apb_o.pslverr = access && pslverr_r;
	assign jerk_set_o = jerk_r;
	assign active_jerk_o = active_jerk_r;
	assign direct_mode_o = ctrl_r[CTRL_DIRECT_MODE_BIT];
	assign clock_frequency_hz_o = freq_r;
	assign compare_position_o = compare_r;
	assign soft_limit_low_o = low_limit_r;
	assign soft_limit_high_o = high_limit_r;
	assign home_position_o = home_r;
	assign circular_span_o = span_r;
	assign goal_position_o = goal_r;
	assign goal_update_o = goal_update_r;
	assign compare_match_o = stat_r[STAT_COMPARE_MATCH_BIT];
	assign below_low_limit_o = stat_r[STAT_BELOW_LOW_BIT];
	assign above_high_limit_o = stat_r[STAT_ABOVE_HIGH_BIT];
	assign outside_span_o = stat_r[STAT_OUTSIDE_SPAN_BIT];
	assign clock_freq_ok_o = stat_r[STAT_CLOCK_OK_BIT];
	assign jerk_ok_o = stat_r[STAT_JERK_OK_BIT];

endmodule

/* File: ramp_param_pkg.sv */
// Shared constants, register map and carrier types of the ramp parameter register group
package ramp_param_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int STRB_W = DATA_W / 8;

	// ----------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_ACCEL_JERK_FIRST = 8'h2D;
	localparam logic [IDX_W-1:0] IDX_ACCEL_JERK_SECOND = 8'h2E;
	localparam logic [IDX_W-1:0] IDX_DECEL_JERK_FIRST = 8'h2F;
	localparam logic [IDX_W-1:0] IDX_DECEL_JERK_SECOND = 8'h30;
	localparam logic [IDX_W-1:0] IDX_CLOCK_FREQUENCY_HZ = 8'h31;
	localparam logic [IDX_W-1:0] IDX_COMPARE_POSITION = 8'h32;
	localparam logic [IDX_W-1:0] IDX_SOFT_LIMIT_LOW = 8'h33;
	localparam logic [IDX_W-1:0] IDX_SOFT_LIMIT_HIGH = 8'h34;
	localparam logic [IDX_W-1:0] IDX_HOME_POSITION = 8'h35;
	localparam logic [IDX_W-1:0] IDX_CAPTURE_OR_SPAN = 8'h36;
	localparam logic [IDX_W-1:0] IDX_GOAL_POSITION = 8'h37;
	localparam logic [IDX_W-1:0] IDX_PARAM_CONTROL = 8'h60;
	localparam logic [IDX_W-1:0] IDX_PARAM_STATUS = 8'h61;

	// ----------------------------------------
	// Field widths and reset values
	// ----------------------------------------
	localparam int JERK_W = 24;
	localparam int FREQ_W = 25;
	localparam int POS_W = 32;
	localparam int SPAN_W = 31;
	localparam int CTRL_W = 2;
	localparam int STAT_W = 7;
	localparam logic [JERK_W-1:0] JERK_RESET = 24'h000000;
	localparam logic [FREQ_W-1:0] FREQ_RESET = 25'h0F42400;
	localparam logic [POS_W-1:0] POS_RESET = 32'h00000000;
	localparam logic [SPAN_W-1:0] SPAN_RESET = 31'h00000000;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

	// ----------------------------------------
	// Value ranges and unit scaling
	// ----------------------------------------
	localparam logic [FREQ_W-1:0] FREQ_MIN_HZ = 25'h0401640;
	localparam logic [FREQ_W-1:0] FREQ_MAX_HZ = 25'h1C9C380;
	localparam logic [JERK_W-1:0] JERK_MIN = 24'h000001;
	localparam int DIRECT_FRAC_BITS = 53;

	// ----------------------------------------
	// Control and status bit positions
	// ----------------------------------------
	localparam int CTRL_LATCH_SEL_BIT = 0;
	localparam int CTRL_DIRECT_MODE_BIT = 1;
	localparam int STAT_COMPARE_MATCH_BIT = 0;
	localparam int STAT_BELOW_LOW_BIT = 1;
	localparam int STAT_ABOVE_HIGH_BIT = 2;
	localparam int STAT_OUTSIDE_SPAN_BIT = 3;
	localparam int STAT_CLOCK_OK_BIT = 4;
	localparam int STAT_JERK_OK_BIT = 5;
	localparam int STAT_CAPTURED_BIT = 6;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		BOW_ACCEL_FIRST = 2'b00,
		BOW_ACCEL_SECOND = 2'b01,
		BOW_DECEL_FIRST = 2'b10,
		BOW_DECEL_SECOND = 2'b11
	} bow_phase_type;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [STRB_W-1:0] pstrb;
	} apb_req_type;

	typedef struct packed
	{
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	typedef struct packed
	{
		logic [JERK_W-1:0] accel_first;
		logic [JERK_W-1:0] accel_second;
		logic [JERK_W-1:0] decel_first;
		logic [JERK_W-1:0] decel_second;
	} jerk_set_type;

endpackage

/* File: host_apb_model.sv */
// Host model: APB master that reaches the parameter registers
`timescale 1ns/100ps
module host_apb_model
(
	// Clock
	input wire logic clk_i,
	// Register bus
	output ramp_param_pkg::apb_req_type req_o,
	input wire ramp_param_pkg::apb_rsp_type rsp_i
);
	import ramp_param_pkg::*;
	initial req_o = '0;
	// Setup cycle, then access held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic e);
		@(posedge clk_i);
		req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
		@(posedge clk_i);
		req_o.penable <= 1'b1;
		do
			@(posedge clk_i);
		while (rsp_i.pready !== 1'b1);
		q = rsp_i.prdata;
		e = rsp_i.pslverr;
		req_o.psel <= 1'b0;
		req_o.penable <= 1'b0;
	endtask
endmodule

/* File: ramp_param_checker.sv */
// Port-level assertions for the ramp parameter register group
`timescale 1ns/100ps
module ramp_param_checker
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Observed ports
	input wire ramp_param_pkg::apb_req_type apb_i,
	input wire ramp_param_pkg::bow_phase_type bow_phase_i,
	input wire logic [ramp_param_pkg::POS_W-1:0] actual_position_i,
	input wire ramp_param_pkg::jerk_set_type jerk_set_o,
	input wire logic [ramp_param_pkg::JERK_W-1:0] active_jerk_o,
	input wire logic direct_mode_o,
	input wire logic [ramp_param_pkg::FREQ_W-1:0] clock_frequency_hz_o,
	input wire logic [ramp_param_pkg::POS_W-1:0] soft_limit_low_o,
	input wire logic [ramp_param_pkg::POS_W-1:0] soft_limit_high_o,
	input wire logic [ramp_param_pkg::SPAN_W-1:0] circular_span_o,
	input wire logic [ramp_param_pkg::POS_W-1:0] goal_position_o,
	input wire logic goal_update_o,
	input wire logic below_low_limit_o,
	input wire logic above_high_limit_o,
	input wire logic jerk_ok_o
);
	import ramp_param_pkg::*;
	logic [IDX_W-1:0] idx;
	logic wr_ok, below_w, above_w, jok_w;
	logic [JERK_W-1:0] act_w;
	assign idx = apb_i.paddr[9:2];
	assign wr_ok = apb_i.psel && apb_i.penable && apb_i.pwrite
		&& (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr[11:10] == 2'h0);
	assign below_w = $signed(actual_position_i) < $signed(soft_limit_low_o);
	assign above_w = $signed(actual_position_i) > $signed(soft_limit_high_o);
	assign jok_w = direct_mode_o || ((|jerk_set_o.accel_first) && (|jerk_set_o.accel_second)
		&& (|jerk_set_o.decel_first) && (|jerk_set_o.decel_second));
	assign act_w = (bow_phase_i == BOW_ACCEL_FIRST) ? jerk_set_o.accel_first :
		(bow_phase_i == BOW_ACCEL_SECOND) ? jerk_set_o.accel_second :
		(bow_phase_i == BOW_DECEL_FIRST) ? jerk_set_o.decel_first : jerk_set_o.decel_second;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_accel_first_load: assert property (wr_ok && idx == IDX_ACCEL_JERK_FIRST
		|=> jerk_set_o.accel_first == $past(apb_i.pwdata[JERK_W-1:0]))
		else $error("first accel jerk missed a write");
	a_active_jerk_sel: assert property (!$past(rst_i) |-> active_jerk_o == $past(act_w))
		else $error("active jerk does not follow phase");
	a_jerk_ok_flag: assert property (!$past(rst_i) |-> jerk_ok_o == $past(jok_w))
		else $error("jerk ok flag wrong");
	a_freq_load: assert property (wr_ok && idx == IDX_CLOCK_FREQUENCY_HZ
		|=> clock_frequency_hz_o == $past(apb_i.pwdata[FREQ_W-1:0]))
		else $error("frequency register missed a write");
	a_freq_default: assert property ($fell(rst_i) |-> clock_frequency_hz_o == FREQ_RESET)
		else $error("frequency default wrong");
	a_low_limit_flag: assert property (!$past(rst_i) |-> below_low_limit_o == $past(below_w))
		else $error("below limit flag wrong");
	a_high_limit_flag: assert property (!$past(rst_i) |-> above_high_limit_o == $past(above_w))
		else $error("above limit flag wrong");
	a_span_load: assert property (wr_ok && idx == IDX_CAPTURE_OR_SPAN
		|=> circular_span_o == $past(apb_i.pwdata[SPAN_W-1:0]))
		else $error("span register missed a write");
	a_goal_load: assert property (wr_ok && idx == IDX_GOAL_POSITION
		|=> goal_update_o && goal_position_o == $past(apb_i.pwdata) ##1 !goal_update_o)
		else $error("goal write or pulse wrong");
endmodule
bind ramp_jerk_target_param_regs ramp_param_checker chk_i (.clk_i, .rst_i, .apb_i, .bow_phase_i,
	.actual_position_i, .jerk_set_o, .active_jerk_o, .direct_mode_o, .clock_frequency_hz_o,
	.soft_limit_low_o, .soft_limit_high_o, .circular_span_o, .goal_position_o, .goal_update_o,
	.below_low_limit_o, .above_high_limit_o, .jerk_ok_o);

/* File: ramp_jerk_target_param_regs_tb.sv */
// Self-checking bench for the ramp parameter register group
`timescale 1ns/100ps
module ramp_jerk_target_param_regs_tb;
	import ramp_param_pkg::*;
	logic clk_i, rst_i, capture_strobe_i, direct_mode_o, goal_update_o;
	apb_req_type apb_i;
	apb_rsp_type apb_o;
	bow_phase_type bow_phase_i;
	logic [POS_W-1:0] actual_position_i, turn_count_i, compare_position_o, home_position_o;
	logic [POS_W-1:0] soft_limit_low_o, soft_limit_high_o, goal_position_o;
	jerk_set_type jerk_set_o;
	logic [JERK_W-1:0] active_jerk_o;
	logic [FREQ_W-1:0] clock_frequency_hz_o;
	logic [SPAN_W-1:0] circular_span_o;
	logic compare_match_o, below_low_limit_o, above_high_limit_o, outside_span_o;
	logic clock_freq_ok_o, jerk_ok_o;
	int num_errors;
	int cmp_count;
	ramp_jerk_target_param_regs dut (.clk_i, .rst_i, .apb_i, .apb_o, .bow_phase_i,
		.actual_position_i, .capture_strobe_i, .turn_count_i, .jerk_set_o, .active_jerk_o,
		.direct_mode_o, .clock_frequency_hz_o, .compare_position_o, .soft_limit_low_o,
		.soft_limit_high_o, .home_position_o, .circular_span_o, .goal_position_o,
		.goal_update_o, .compare_match_o, .below_low_limit_o, .above_high_limit_o,
		.outside_span_o, .clock_freq_ok_o, .jerk_ok_o);
	host_apb_model host (.clk_i, .req_o(apb_i), .rsp_i(apb_o));
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] i, input logic [31:0] exp, input logic err);
		logic [31:0] q;
		logic e;
		host.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, q, e);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		host.xfer(1'b1, {2'h0, i, 2'h0}, d, q, e);
		chk({31'h0, e}, 32'h0);
	endtask
	function automatic logic [31:0] msk(input int i);
		return (i <= 8'h30) ? 32'h00FFFFFF : (i == 8'h31) ? 32'h01FFFFFF : 32'hFFFFFFFF;
	endfunction
	task automatic end_of_test;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial
	begin
		#400000;
		num_errors++;
		end_of_test;
	end
	initial
	begin
		rst_i = 1'b1;
		bow_phase_i = BOW_ACCEL_FIRST;
		actual_position_i = '0;
		capture_strobe_i = 1'b0;
		turn_count_i = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 8'h2D; i <= 8'h37; i++)
			rdc(i[7:0], (i == 8'h31) ? {7'h0, FREQ_RESET} : 32'h0, 1'b0);
		$display("test reset done");
		for (int i = 8'h2D; i <= 8'h37; i++)
			if (i != 8'h36)
				wr(i[7:0], 32'hC3A50000 + i);
		for (int i = 8'h2D; i <= 8'h37; i++)
			if (i != 8'h36)
				rdc(i[7:0], (32'hC3A50000 + i) & msk(i), 1'b0);
		chk(home_position_o, 32'hC3A50035);
		for (int p = 0; p < 4; p++)
		begin
			bow_phase_i <= bow_phase_type'(p);
			repeat (2) @(posedge clk_i);
			chk({8'h0, active_jerk_o}, 32'h00A5002D + p);
		end
		$display("test readback done");
		wr(8'h36, 32'hFFFFFFFF);
		@(posedge clk_i);
		chk({1'b0, circular_span_o}, 32'h7FFFFFFF);
		rdc(8'h36, 32'h0, 1'b0);
		actual_position_i <= 32'h80000000;
		capture_strobe_i <= 1'b1;
		@(posedge clk_i);
		capture_strobe_i <= 1'b0;
		@(posedge clk_i);
		chk({30'h0, outside_span_o, below_low_limit_o}, 32'h3);
		rdc(8'h36, 32'h80000000, 1'b0);
		wr(8'h60, 32'h1);
		turn_count_i <= 32'hFFFFFFFE;
		actual_position_i <= 32'h7FFFFFF0;
		rdc(8'h36, 32'hFFFFFFFE, 1'b0);
		chk({30'h0, above_high_limit_o, below_low_limit_o}, 32'h2);
		$display("test latch done");
		rdc(8'h2C, 32'h0, 1'b1);
		wr(8'h2D, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, jerk_ok_o}, 32'h0);
		wr(8'h60, 32'h3);
		repeat (2) @(posedge clk_i);
		chk({30'h0, direct_mode_o, jerk_ok_o}, 32'h3);
		rdc(8'h60, 32'h3, 1'b0);
		actual_position_i <= 32'hC3A50032;
		capture_strobe_i <= 1'b1;
		@(posedge clk_i);
		capture_strobe_i <= 1'b0;
		wr(8'h31, 32'h003D0900);
		repeat (2) @(posedge clk_i);
		chk({30'h0, compare_match_o, clock_freq_ok_o}, 32'h2);
		rdc(8'h61, 32'h00000063, 1'b0);
		$display("test mode done");
		end_of_test;
	end
endmodule
